// File: rtl/agen_cfg.svh
// address generator constants: register map, field positions, reset values, limits
`ifndef AGEN_CFG_SVH
`define AGEN_CFG_SVH

// register byte offsets
`define AGEN_OFF_CTRL 12'h000
`define AGEN_OFF_STATUS 12'h004
`define AGEN_OFF_MASK 12'h008
`define AGEN_OFF_LAST_OFFSET 12'h00C
`define AGEN_OFF_LAST_LINEAR 12'h010
`define AGEN_OFF_LAST_INFO 12'h014

// control fields
`define AGEN_CTRL_CODE_SIZE 0
`define AGEN_CTRL_REAL 1
`define AGEN_CTRL_PAGING 2
`define AGEN_CTRL_CODE_SIZE_RST 1'h0
`define AGEN_CTRL_REAL_RST 1'h1
`define AGEN_CTRL_PAGING_RST 1'h0

// status and mask fields
`define AGEN_EVT_DONE 0
`define AGEN_EVT_PROT 1
`define AGEN_EVT_FORM 2
`define AGEN_EVT_WIDTH 3
`define AGEN_STATUS_RST 3'h0
`define AGEN_MASK_RST 3'h0

// general register numbers
`define AGEN_GPR_STACK_POINTER 3'h4
`define AGEN_GPR_GENERAL_BASE 3'h3
`define AGEN_GPR_FRAME_BASE 3'h5
`define AGEN_GPR_SOURCE_INDEX 3'h6
`define AGEN_GPR_DEST_INDEX 3'h7

// address limits and shapes
`define AGEN_REAL_LIMIT 32'h0000FFFF
`define AGEN_SEG_SHIFT 4
`define AGEN_PAGE_BITS 12
`define AGEN_EXTRA_CLKS 1

`endif

// File: rtl/agen_pkg.sv
// types shared by the address generator files
package agen_pkg;

    typedef enum logic [1:0] {DISP_NONE, DISP_8, DISP_16, DISP_32} disp_kind_t;

    typedef enum logic [1:0] {SIZE_BYTE, SIZE_WORD, SIZE_DWORD, SIZE_RSVD} access_size_t;

    typedef enum {ST_IDLE, ST_CALC, ST_EXTRA} agen_state_t;

    typedef struct packed {
        logic useBase;
        logic [2:0] baseSel;
        logic useIndex;
        logic [2:0] indexSel;
        logic [1:0] scaleLog;
        disp_kind_t dispKind;
        logic [31:0] disp;
        logic operandPrefix;
        logic addressPrefix;
        access_size_t accessSize;
        logic [31:0] segBase;
        logic [15:0] segSelector;
    } addr_req_t;

    typedef struct packed {
        logic [31:0] effAddr;
        logic [31:0] linearAddr;
        logic [31:0] lastByteAddr;
        logic [19:0] pageNumber;
        logic [11:0] pageOffset;
        logic pageCross;
        logic operand32;
        logic address32;
        logic protFault;
        logic formFault;
    } addr_resp_t;

endpackage

// File: rtl/offset_adder.sv
// base plus scaled index plus displacement, wrapped to the active address size
`timescale 1ns/1ps
module offset_adder
    import agen_pkg::*;
(
    input wire logic [31:0] baseVal,
    input wire logic [31:0] indexVal,
    input wire logic useBase,
    input wire logic useIndex,
    input wire logic [1:0] scaleLog,
    input wire logic [31:0] dispExt,
    input wire logic address32,
    output logic [31:0] effAddr
);
    logic [31:0] baseTerm;
    logic [31:0] indexTerm;
    logic [31:0] sum;

    // unused parts count as zero
    assign baseTerm = useBase ? baseVal : 32'h00000000;
    // scale of 1, 2, 4 or 8 is a shift of 0..3
    assign indexTerm = useIndex ? (indexVal << scaleLog) : 32'h00000000;
    // two's complement wrap: carries out of bit 31 are dropped
    assign sum = baseTerm + indexTerm + dispExt;
    assign effAddr = address32 ? sum : {16'h0000, sum[15:0]};
endmodule // offset_adder

// File: rtl/effective_address_generator.sv
// effective and linear address generation with APB control and status
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
//
// Contract
// - offset is base plus scaled index plus displacement
// - scale one, two, four, eight as shift
// - 32-bit: any base, index not stack pointer
// - 32-bit: displacement none, 8 or 32
// - 16-bit: displacement none, 8 or 16
// - 16-bit: limited base and index, no scale
// - base with index costs one extra clock
// - code segment size flag picks default sizes
// - real mode defaults to 16-bit sizes
// - prefixes invert default sizes per instruction
// - real mode offset above FFFFH faults
// - linear is segment base plus offset
// - direct mode uses displacement alone
// - multibyte values little endian in consecutive bytes
// - value address is its lowest byte
// - two's complement arithmetic throughout
// - paging uses 4K byte pages
// - real mode linear is selector shl 4 plus offset
module effective_address_generator
    import agen_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // decoder and register file side
    input wire logic reqValid,
    input wire addr_req_t req,
    input wire logic [7:0][31:0] gprValues,
    output logic reqReady,
    // memory path side
    output logic respValid,
    output addr_resp_t resp,
    output logic irq
);

    `include "agen_cfg.svh"

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        agen_state_t state;
        addr_req_t req;
        logic [31:0] baseVal;
        logic [31:0] indexVal;
        addr_resp_t resp;
        logic respValid;
        logic reqReady;
        logic ctrlCodeSize;
        logic ctrlReal;
        logic ctrlPaging;
        logic [`AGEN_EVT_WIDTH-1:0] status;
        logic [`AGEN_EVT_WIDTH-1:0] mask;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } agen_regs_t;

    agen_regs_t r;
    agen_regs_t next_r;

    // ------------------------------------------------------------
    // address size and form checks on the captured request
    // ------------------------------------------------------------
    logic default32, operand32, address32;
    logic [1:0] scaleUsed;
    logic [31:0] dispExt, offsetSum, effAddr, segPart, linearAddr, lastByteAddr, spanBytes;
    logic formBad, protBad, needExtra;

    always_comb
    begin
        // real mode forces 16-bit defaults regardless of the size flag
        default32 = r.ctrlCodeSize & ~r.ctrlReal;
        // in real mode the address prefix only unlocks the 32-bit forms
        operand32 = default32 ^ r.req.operandPrefix;
        address32 = default32 ^ r.req.addressPrefix;
    end

    always_comb
    begin
        unique case (r.req.dispKind)
            DISP_NONE:
            begin
                dispExt = 32'h00000000;
            end
            DISP_8:
            begin
                dispExt = {{24{r.req.disp[7]}}, r.req.disp[7:0]};
            end
            DISP_16:
            begin
                dispExt = {{16{r.req.disp[15]}}, r.req.disp[15:0]};
            end
            DISP_32:
            begin
                dispExt = r.req.disp;
            end
        endcase
    end

    always_comb
    begin
        formBad = 1'b0;
        scaleUsed = r.req.scaleLog;
        if (address32)
        begin
            // any register may be base; stack pointer may not be index
            if (r.req.useIndex && r.req.indexSel == `AGEN_GPR_STACK_POINTER)
            begin
                formBad = 1'b1;
            end
            if (r.req.dispKind == DISP_16)
            begin
                formBad = 1'b1;
            end
        end
        else
        begin
            // the 16-bit form has no scaling; a supplied scale is ignored
            scaleUsed = 2'h0;
            if (r.req.useBase && r.req.baseSel != `AGEN_GPR_GENERAL_BASE
                && r.req.baseSel != `AGEN_GPR_FRAME_BASE)
            begin
                formBad = 1'b1;
            end
            if (r.req.useIndex && r.req.indexSel != `AGEN_GPR_SOURCE_INDEX
                && r.req.indexSel != `AGEN_GPR_DEST_INDEX)
            begin
                formBad = 1'b1;
            end
            if (r.req.dispKind == DISP_32)
            begin
                formBad = 1'b1;
            end
        end
    end

    // direct mode falls out of the same sum with both registers unused
    offset_adder u_adder (
        .baseVal(r.baseVal),
        .indexVal(r.indexVal),
        .useBase(r.req.useBase),
        .useIndex(r.req.useIndex),
        .scaleLog(scaleUsed),
        .dispExt(dispExt),
        .address32(address32),
        .effAddr(offsetSum)
    );

    always_comb
    begin
        effAddr = offsetSum;
        protBad = r.ctrlReal && (offsetSum > `AGEN_REAL_LIMIT);
        if (r.ctrlReal)
        begin
            segPart = {12'h000, r.req.segSelector, 4'h0};
        end
        else
        begin
            segPart = r.req.segBase;
        end
        linearAddr = segPart + effAddr;
        unique case (r.req.accessSize)
            SIZE_BYTE:
            begin
                spanBytes = 32'h00000000;
            end
            SIZE_WORD:
            begin
                spanBytes = 32'h00000001;
            end
            default:
            begin
                spanBytes = 32'h00000003;
            end
        endcase
        // value sits low byte first; its address is the lowest byte
        lastByteAddr = linearAddr + spanBytes;
        needExtra = r.req.useBase && r.req.useIndex;
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic apbAccess;
    logic mapped;
    logic [31:0] readMux;
    logic doWrite;
    logic [`AGEN_EVT_WIDTH-1:0] evtSet;
    logic [`AGEN_EVT_WIDTH-1:0] evtClr;

    assign apbAccess = psel & penable;
    assign doWrite = apbAccess & r.pready & pwrite;

    always_comb
    begin
        mapped = 1'b1;
        readMux = 32'h00000000;
        unique case (paddr)
            `AGEN_OFF_CTRL:
            begin
                readMux[`AGEN_CTRL_CODE_SIZE] = r.ctrlCodeSize;
                readMux[`AGEN_CTRL_REAL] = r.ctrlReal;
                readMux[`AGEN_CTRL_PAGING] = r.ctrlPaging;
            end
            `AGEN_OFF_STATUS:
            begin
                readMux[`AGEN_EVT_WIDTH-1:0] = r.status;
            end
            `AGEN_OFF_MASK:
            begin
                readMux[`AGEN_EVT_WIDTH-1:0] = r.mask;
            end
            `AGEN_OFF_LAST_OFFSET:
            begin
                readMux = r.resp.effAddr;
            end
            `AGEN_OFF_LAST_LINEAR:
            begin
                readMux = r.resp.linearAddr;
            end
            `AGEN_OFF_LAST_INFO:
            begin
                readMux[5:0] = {r.resp.pageCross, r.resp.operand32, r.resp.address32,
                                r.resp.protFault, r.resp.formFault, r.respValid};
            end
            default:
            begin
                mapped = 1'b0;
            end
        endcase
    end

    assign evtClr = (doWrite && paddr == `AGEN_OFF_STATUS) ? pwdata[`AGEN_EVT_WIDTH-1:0] : '0;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_r = r;
        evtSet = '0;
        next_r.respValid = 1'b0;

        unique case (r.state)
            ST_IDLE:
            begin
                if (reqValid)
                begin
                    next_r.req = req;
                    next_r.baseVal = gprValues[req.baseSel];
                    next_r.indexVal = gprValues[req.indexSel];
                    next_r.state = ST_CALC;
                end
            end
            ST_CALC:
            begin
                // base with index holds one clock longer in ST_EXTRA; the same one-cycle sum is captured there
                if (needExtra)
                begin
                    next_r.state = ST_EXTRA;
                end
                else
                begin
                    next_r.state = ST_IDLE;
                    next_r.respValid = 1'b1;
                end
            end
            ST_EXTRA:
            begin
                next_r.state = ST_IDLE;
                next_r.respValid = 1'b1;
            end
        endcase

        if (next_r.respValid)
        begin
            next_r.resp.effAddr = effAddr;
            next_r.resp.linearAddr = linearAddr;
            next_r.resp.lastByteAddr = lastByteAddr;
            next_r.resp.pageNumber = linearAddr[31:`AGEN_PAGE_BITS];
            next_r.resp.pageOffset = linearAddr[`AGEN_PAGE_BITS-1:0];
            next_r.resp.pageCross = r.ctrlPaging
                && (lastByteAddr[31:`AGEN_PAGE_BITS] != linearAddr[31:`AGEN_PAGE_BITS]);
            next_r.resp.operand32 = operand32;
            next_r.resp.address32 = address32;
            next_r.resp.protFault = protBad;
            next_r.resp.formFault = formBad;
            evtSet[`AGEN_EVT_DONE] = 1'b1;
            evtSet[`AGEN_EVT_PROT] = protBad;
            evtSet[`AGEN_EVT_FORM] = formBad;
        end
        next_r.reqReady = (next_r.state == ST_IDLE);

        // APB: one wait state, then the answer; writes land on the ready edge
        next_r.pready = 1'b0;
        if (apbAccess && !r.pready)
        begin
            next_r.pready = 1'b1;
            next_r.pslverr = ~mapped;
            next_r.prdata = pwrite ? 32'h00000000 : readMux;
        end
        if (doWrite && paddr == `AGEN_OFF_CTRL)
        begin
            next_r.ctrlCodeSize = pwdata[`AGEN_CTRL_CODE_SIZE];
            next_r.ctrlReal = pwdata[`AGEN_CTRL_REAL];
            next_r.ctrlPaging = pwdata[`AGEN_CTRL_PAGING];
        end
        if (doWrite && paddr == `AGEN_OFF_MASK)
        begin
            next_r.mask = pwdata[`AGEN_EVT_WIDTH-1:0];
        end

        // a new event beats a clear in the same cycle
        next_r.status = (r.status & ~evtClr) | evtSet;
        next_r.irq = |(next_r.status & next_r.mask);
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            r <= '0;
            r.state <= ST_IDLE;
            r.reqReady <= 1'b1;
            r.ctrlCodeSize <= `AGEN_CTRL_CODE_SIZE_RST;
            r.ctrlReal <= `AGEN_CTRL_REAL_RST;
            r.ctrlPaging <= `AGEN_CTRL_PAGING_RST;
            r.status <= `AGEN_STATUS_RST;
            r.mask <= `AGEN_MASK_RST;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign reqReady = r.reqReady;
    assign respValid = r.respValid;
    assign resp = r.resp;
    assign irq = r.irq;

endmodule // effective_address_generator

// File: bench/agen_chk.sv
// concurrent checks on the address generator ports
`timescale 1ns/1ps
module agen_chk
    import agen_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic reqValid,
    input wire addr_req_t req,
    input wire logic reqReady,
    input wire logic respValid,
    input wire addr_resp_t resp
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire take = reqValid && reqReady;
    wire both = req.useBase && req.useIndex;
    sequence s_calc;
        !respValid && !reqReady;
    endsequence
    a_one_pass: assert property (take && !both |=> s_calc ##1 respValid)
        else $error("answer not two edges after take");
    a_extra_clock: assert property (take && both |=> s_calc [*2] ##1 respValid)
        else $error("base with index answer not three edges after take");
    a_ready_back: assert property (respValid |-> reqReady ##1 !respValid)
        else $error("ready missing or answer too long");
    a_resp_hold: assert property (!respValid |-> $stable(resp))
        else $error("answer changed without valid");
    a_wrap_short: assert property (respValid && !resp.address32 |-> resp.effAddr[31:16] == 16'h0)
        else $error("short offset not wrapped");
    a_real_fault: assert property (respValid && resp.protFault |-> resp.effAddr > 32'h0000FFFF)
        else $error("fault on small offset");
    a_page_split: assert property (respValid |-> {resp.pageNumber, resp.pageOffset} == resp.linearAddr)
        else $error("page split wrong");
    a_last_byte: assert property (respValid |-> (resp.lastByteAddr - resp.linearAddr) inside {32'h0, 32'h1, 32'h3})
        else $error("last byte address wrong");
    a_apb_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("bus answer not one wait state");
endmodule // agen_chk

bind effective_address_generator agen_chk chk (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .reqValid(reqValid), .req(req),
    .reqReady(reqReady), .respValid(respValid), .resp(resp));

// File: bench/decoder_model.sv
// decoder and register file model feeding the address generator
`timescale 1ns/1ps
module decoder_model
    import agen_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic go,
    input wire addr_req_t reqIn,
    input wire logic reqReady,
    output logic reqValid,
    output addr_req_t req,
    output logic [7:0][31:0] gprValues
);
    // large values so short sums wrap and real mode offsets can overflow
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            gprValues[i] = 32'h90000000 + 32'(i) * 32'h00003001;
        end
    end
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            reqValid <= 1'b0;
            req <= '0;
        end
        else if (go)
        begin
            reqValid <= 1'b1;
            req <= reqIn;
        end
        else if (reqValid && reqReady)
            reqValid <= 1'b0;
        else if (!reqValid)
            req <= ~req; // released lines keep moving so a stale sample shows
    end
endmodule // decoder_model

// File: bench/effective_address_generator_bench.sv
// self-checking bench for the address generator
`timescale 1ns/1ps
module effective_address_generator_bench
    import agen_pkg::*;
;
    logic core_clk, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
    logic pready, pslverr, reqValid, reqReady, respValid, irq, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, off;
    logic [7:0][31:0] gpr;
    logic [2:0] ctl = 3'h2;
    addr_req_t req, reqIn = '0;
    addr_resp_t resp;
    int fails = 0, cmp_count = 0, cyc = 0;
    effective_address_generator dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reqValid(reqValid), .req(req), .gprValues(gpr), .reqReady(reqReady), .respValid(respValid),
        .resp(resp), .irq(irq));
    decoder_model partner (.core_clk(core_clk), .sys_rst(sys_rst), .go(go), .reqIn(reqIn),
        .reqReady(reqReady), .reqValid(reqValid), .req(req), .gprValues(gpr));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (w && a == 12'h000 && !er) ctl = d[2:0];
    endtask
    function automatic addr_req_t mk(logic ub, logic [2:0] b, logic ui, logic [2:0] x, logic [1:0] s,
        disp_kind_t k, logic [31:0] d, logic [1:0] pf, access_size_t z);
        mk = {ub, b, ui, x, s, k, d, pf, z, 32'h00200000, 16'h1234};
    endfunction
    task addr(input addr_req_t r);
        logic a32, rl, fm;
        logic [31:0] b, x, dx, lin, last;
        int n;
        a32 = (ctl[0] & ~ctl[1]) ^ r.addressPrefix;
        rl = ctl[1];
        b = r.useBase ? gpr[r.baseSel] : 32'h0;
        x = r.useIndex ? gpr[r.indexSel] << (a32 ? r.scaleLog : 2'h0) : 32'h0;
        dx = r.dispKind == DISP_8 ? {{24{r.disp[7]}}, r.disp[7:0]} : r.dispKind == DISP_16 ?
            {{16{r.disp[15]}}, r.disp[15:0]} : r.dispKind == DISP_32 ? r.disp : 32'h0;
        off = b + x + dx;
        if (!a32) off[31:16] = 16'h0;
        lin = (rl ? {12'h0, r.segSelector, 4'h0} : r.segBase) + off;
        last = lin + (r.accessSize == SIZE_BYTE ? 32'h0 : r.accessSize == SIZE_WORD ? 32'h1 : 32'h3);
        fm = a32 ? (r.useIndex && r.indexSel == 3'h4) || r.dispKind == DISP_16 : (r.useBase && r.baseSel != 3'h3
            && r.baseSel != 3'h5) || (r.useIndex && r.indexSel < 3'h6) || r.dispKind == DISP_32;
        @(posedge core_clk);
        reqIn <= r;
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        n = 0;
        while (respValid !== 1'b1)
        begin
            @(posedge core_clk);
            n++;
        end
        chk(32'(n), 32'(3 + (r.useBase && r.useIndex)));
        chk(resp.effAddr, off);
        chk(resp.linearAddr, lin);
        chk(resp.lastByteAddr, last);
        chk(32'({resp.operand32, resp.address32, resp.protFault, resp.formFault, resp.pageCross}),
            32'({(ctl[0] & ~ctl[1]) ^ r.operandPrefix, a32, rl && off > 32'h0000FFFF, fm,
            ctl[2] && lin[31:12] != last[31:12]}));
    endtask
    task t_regs;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h2);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h018, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        $display("registers test done");
    endtask
    task t_real;
        addr(mk(1, 3'h3, 0, 3'h0, 2'h0, DISP_16, 32'h0000FFF0, 2'h0, SIZE_WORD));
        apb(1'b0, 12'h00C, 32'h0);
        chk(rd, off);
        addr(mk(1, 3'h3, 1, 3'h6, 2'h2, DISP_8, 32'h80, 2'h1, SIZE_DWORD));
        addr(mk(1, 3'h3, 0, 3'h0, 2'h0, DISP_32, 32'h10, 2'h2, SIZE_BYTE));
        $display("real mode test done");
    endtask
    task t_flat;
        apb(1'b1, 12'h000, 32'h1);
        for (int s = 0; s < 4; s++) addr(mk(1, 3'h1, 1, 3'h2, 2'(s), DISP_8, 32'hF0, 2'h0, SIZE_DWORD));
        addr(mk(1, 3'h4, 1, 3'h4, 2'h1, DISP_32, 32'h100, 2'h0, SIZE_WORD));
        addr(mk(0, 3'h0, 0, 3'h0, 2'h0, DISP_16, 32'h1234, 2'h0, SIZE_BYTE));
        addr(mk(0, 3'h0, 0, 3'h0, 2'h0, DISP_32, 32'hFFFFFFF0, 2'h2, SIZE_WORD));
        addr(mk(1, 3'h7, 0, 3'h0, 2'h0, DISP_NONE, 32'h0, 2'h0, SIZE_DWORD));
        // both prefixes together drop operands and addresses to 16 bits
        addr(mk(1, 3'h3, 1, 3'h6, 2'h3, DISP_8, 32'hFE, 2'h3, SIZE_WORD));
        $display("32-bit test done");
    endtask
    task t_short;
        apb(1'b1, 12'h000, 32'h0);
        addr(mk(1, 3'h5, 1, 3'h7, 2'h3, DISP_16, 32'h1234, 2'h0, SIZE_WORD));
        addr(mk(1, 3'h0, 1, 3'h6, 2'h0, DISP_8, 32'h7F, 2'h0, SIZE_BYTE));
        addr(mk(1, 3'h3, 1, 3'h2, 2'h0, DISP_NONE, 32'h0, 2'h0, SIZE_BYTE));
        addr(mk(0, 3'h0, 1, 3'h6, 2'h1, DISP_NONE, 32'h0, 2'h1, SIZE_BYTE));
        $display("16-bit test done");
    endtask
    task t_page;
        apb(1'b1, 12'h000, 32'h5);
        addr(mk(0, 3'h0, 0, 3'h0, 2'h0, DISP_32, 32'hFFE, 2'h0, SIZE_DWORD));
        addr(mk(0, 3'h0, 0, 3'h0, 2'h0, DISP_32, 32'hFFC, 2'h0, SIZE_DWORD));
        $display("paging test done");
    endtask
    task t_irq;
        apb(1'b1, 12'h004, 32'h7);
        apb(1'b1, 12'h008, 32'h0);
        addr(mk(0, 3'h0, 0, 3'h0, 2'h0, DISP_NONE, 32'h0, 2'h0, SIZE_BYTE));
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h1);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 12'h008, 32'h1);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, 12'h004, 32'h1);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        // an event arriving while its mask bit is already set raises the interrupt
        apb(1'b1, 12'h008, 32'h4);
        addr(mk(0, 3'h0, 1, 3'h4, 2'h0, DISP_NONE, 32'h0, 2'h0, SIZE_BYTE));
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h5);
        apb(1'b1, 12'h000, 32'h2);
        addr(mk(1, 3'h3, 0, 3'h0, 2'h0, DISP_NONE, 32'h0, 2'h1, SIZE_BYTE));
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h7);
        apb(1'b0, 12'h014, 32'h0);
        chk(rd, 32'h0000000C);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h00012340 + off);
        $display("interrupt test done");
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            summarize();
        end
    end
    initial
    begin
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_real();
        t_flat();
        t_short();
        t_page();
        t_irq();
        summarize();
    end
endmodule // effective_address_generator_bench
